// [common/brf_pkg.sv]
package brf_pkg;

  // Register port
  localparam int unsigned BRF_AW = 8;
  localparam int unsigned BRF_DW = 32;

  localparam logic [BRF_AW-1:0] BRF_CTRL_OFS = 8'h00;
  localparam logic [BRF_AW-1:0] BRF_STAT_OFS = 8'h04;
  localparam logic [BRF_AW-1:0] BRF_MASK_OFS = 8'h08;
  localparam logic [BRF_AW-1:0] BRF_CFG_OFS  = 8'h0C;

  // Forwarding control register
  localparam int unsigned       BRF_CTRL_W     = 16;
  localparam logic [15:0]       BRF_CTRL_RST   = 16'h0000;
  localparam int unsigned       BRF_PERR_EN    = 0;
  localparam int unsigned       BRF_SERR_FWD   = 1;
  localparam int unsigned       BRF_ISA_EN     = 2;

  // Event status / mask layout
  localparam int unsigned       BRF_EV_W       = 6;
  localparam logic [5:0]        BRF_EV_RST     = 6'h00;
  localparam int unsigned       BRF_EV_SERR    = 0;
  localparam int unsigned       BRF_EV_PERRDET = 1;
  localparam int unsigned       BRF_EV_MDERR   = 2;
  localparam int unsigned       BRF_EV_STA     = 3;
  localparam int unsigned       BRF_EV_SERRSIG = 4;
  localparam int unsigned       BRF_EV_FLOOD   = 5;

  // Error pin routing
  localparam int unsigned       BRF_CFG_W      = 2;
  localparam logic [1:0]        BRF_CFG_RST    = 2'h0;
  localparam int unsigned       BRF_CFG_SERR_FATAL = 0;
  localparam int unsigned       BRF_CFG_PERR_FATAL = 1;

  // I/O decode
  localparam int unsigned       BRF_IO_AW      = 32;
  localparam int unsigned       BRF_IO_64K_LSB = 16;
  localparam int unsigned       BRF_ISA_LO     = 8;
  localparam int unsigned       BRF_ISA_HI     = 9;
  localparam logic [1:0]        BRF_ISA_LOW256 = 2'h0;

  typedef enum logic {BRF_MODE_STD, BRF_MODE_ALT} brf_mode_e;

  typedef struct packed {
    logic                 valid;
    logic                 upstream;
    logic [BRF_IO_AW-1:0] addr;
  } brf_io_req_s;

  typedef struct packed {
    logic addr_perr;
    logic mst_data_perr;
    logic tgt_data_perr;
    logic tgt_abort;
  } brf_perr_s;

endpackage : brf_pkg

// [rtl/brf_bridge_ctl.sv]
// Operation
// - ISA filtering only touches I/O addresses inside the base/limit window and below 64 Kbytes.
// - With ISA filtering on, downstream I/O to the upper 768 bytes of each 1 Kbyte block is refused.
// - With ISA filtering on, upstream I/O to the upper 768 bytes of each 1 Kbyte block is passed.
// - With ISA filtering off, every I/O address in the window is forwarded downstream.
// - The three control bits read zero after every reset, warm or cold.
// - In the standard modes a secondary SERR# with both enables drives a fatal or nonfatal error pin.
// - In the alternate modes a secondary SERR# with both enables floods both primary links with sync.
// - In the standard modes parity errors reach the error pins only while parity response is enabled.
// - In the alternate modes master data error and parity forwarding require the response enable.
// - In the alternate modes a secondary address parity error with response enabled floods both links if SERR enable is set.
// - A secondary address parity error with response enabled sets parity detected and SERR signaled.
// - If the bridge claimed that cycle and target-aborted it, signaled target abort is also set.
// - A data parity error seen as secondary master with response enabled sets master data error.
// - A data parity error seen as secondary target with response enabled sets parity detected.
// - A secondary data parity error detected with response enabled marks the related primary packet with data error.
module brf_bridge_ctl
  import brf_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic [BRF_AW-1:0]     reg_addr,
  input  wire logic [BRF_DW-1:0]     reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [BRF_DW-1:0]     reg_rdata,
  input  wire logic                  alt_mode_sel,
  input  wire logic                  cmd_serr_enable,
  input  wire logic [BRF_IO_AW-1:0]  io_base,
  input  wire logic [BRF_IO_AW-1:0]  io_limit,
  input  wire brf_io_req_s           io_req,
  output logic                       io_fwd_valid,
  output logic                       io_fwd_ok,
  input  wire brf_perr_s             sec_perr,
  input  wire logic                  sec_serr_n,
  input  wire logic                  link_clk,
  output logic                       sync_flood,
  output logic                       link0_sync_stb,
  output logic                       link1_sync_stb,
  output logic                       pkt_data_error,
  output logic                       fatal_error_out_n,
  output logic                       nonfatal_error_out_n,
  output logic                       primary_parity_error_out_n,
  output logic                       irq
);

  logic [BRF_CTRL_W-1:0] ctrl_q;
  logic [BRF_EV_W-1:0]   stat_q;
  logic [BRF_EV_W-1:0]   mask_q;
  logic [BRF_CFG_W-1:0]  cfg_q;
  logic [BRF_EV_W-1:0]   ev_set;
  logic [BRF_DW-1:0]     rdata_q;
  brf_mode_e             mode_q;
  logic                  mode_s1_q;
  logic                  mode_s2_q;
  logic                  serr_s1_q;
  logic                  serr_s2_q;
  logic                  serr_s3_q;
  logic                  lclk_s1_q;
  logic                  lclk_s2_q;
  logic                  lclk_s3_q;
  logic                  flood_q;
  logic                  fwd_valid_q;
  logic                  fwd_ok_q;
  logic                  fatal_n_q;
  logic                  nonfatal_n_q;
  logic                  pperr_n_q;
  logic                  pkt_derr_q;
  logic                  l0_stb_q;
  logic                  l1_stb_q;
  logic                  irq_q;

  logic                  isa_en;
  logic                  serr_fwd_en;
  logic                  perr_en;
  logic                  serr_event;
  logic                  serr_fwd;
  logic                  aperr;
  logic                  dperr;
  logic                  flood_req;
  logic                  in_window;
  logic                  below_64k;
  logic                  isa_alias;
  logic                  isa_hit;
  logic                  fwd_ok_d;
  logic                  lclk_rise;
  logic                  std_mode;

  assign isa_en      = ctrl_q[BRF_ISA_EN];
  assign serr_fwd_en = ctrl_q[BRF_SERR_FWD];
  assign perr_en     = ctrl_q[BRF_PERR_EN];
  assign std_mode    = (mode_q == BRF_MODE_STD);

  // Strap synchroniser runs through reset, so the strap is already settled when it is caught
  always_ff @(posedge clk) begin
    mode_s1_q <= alt_mode_sel;
    mode_s2_q <= mode_s1_q;
  end

  // Pin inputs from other domains pass two flops first
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      serr_s1_q <= 1'b1;
      serr_s2_q <= 1'b1;
      serr_s3_q <= 1'b1;
      lclk_s1_q <= 1'b0;
      lclk_s2_q <= 1'b0;
      lclk_s3_q <= 1'b0;
    end else begin
      serr_s1_q <= sec_serr_n;
      serr_s2_q <= serr_s1_q;
      serr_s3_q <= serr_s2_q;
      lclk_s1_q <= link_clk;
      lclk_s2_q <= lclk_s1_q;
      lclk_s3_q <= lclk_s2_q;
    end
  end

  // Mode is a strap: sampled only while reset is held, so it never moves in service
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_q <= mode_s2_q ? BRF_MODE_ALT : BRF_MODE_STD;
    end
  end

  assign serr_event = serr_s3_q && !serr_s2_q;
  assign lclk_rise  = lclk_s2_q && !lclk_s3_q;
  assign serr_fwd   = serr_event && serr_fwd_en && cmd_serr_enable;
  assign aperr      = sec_perr.addr_perr && perr_en;
  assign dperr      = (sec_perr.mst_data_perr || sec_perr.tgt_data_perr) && perr_en;

  // Sync flood is terminal: only a reset of the bridge ends it
  assign flood_req = !std_mode && (serr_fwd || (aperr && cmd_serr_enable));

  // I/O address decode
  always_comb begin
    in_window = (io_req.addr >= io_base) && (io_req.addr <= io_limit);
    below_64k = (io_req.addr[BRF_IO_AW-1:BRF_IO_64K_LSB] == '0);
    isa_alias = (io_req.addr[BRF_ISA_HI:BRF_ISA_LO] != BRF_ISA_LOW256);
    isa_hit   = isa_en && in_window && below_64k && isa_alias;
    if (io_req.upstream) begin
      fwd_ok_d = !in_window || isa_hit;
    end else begin
      fwd_ok_d = in_window && !isa_hit;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fwd_valid_q <= 1'b0;
      fwd_ok_q    <= 1'b0;
    end else begin
      fwd_valid_q <= io_req.valid;
      fwd_ok_q    <= io_req.valid && fwd_ok_d;
    end
  end

  // Event sources
  always_comb begin
    ev_set                 = '0;
    ev_set[BRF_EV_SERR]    = serr_fwd;
    ev_set[BRF_EV_PERRDET] = aperr || (sec_perr.tgt_data_perr && perr_en);
    ev_set[BRF_EV_MDERR]   = sec_perr.mst_data_perr && perr_en;
    ev_set[BRF_EV_STA]     = aperr && sec_perr.tgt_abort;
    ev_set[BRF_EV_SERRSIG] = aperr || serr_fwd;
    ev_set[BRF_EV_FLOOD]   = flood_req && !flood_q;
  end

  // Control registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= BRF_CTRL_RST;
      mask_q <= BRF_EV_RST;
      cfg_q  <= BRF_CFG_RST;
    end else if (reg_wr) begin
      if (reg_addr == BRF_CTRL_OFS) begin
        ctrl_q[BRF_PERR_EN]  <= reg_wdata[BRF_PERR_EN];
        ctrl_q[BRF_SERR_FWD] <= reg_wdata[BRF_SERR_FWD];
        ctrl_q[BRF_ISA_EN]   <= reg_wdata[BRF_ISA_EN];
      end else if (reg_addr == BRF_MASK_OFS) begin
        mask_q <= reg_wdata[BRF_EV_W-1:0];
      end else if (reg_addr == BRF_CFG_OFS) begin
        cfg_q <= reg_wdata[BRF_CFG_W-1:0];
      end
    end
  end

  // Sticky status, cleared by a read; a new event in that cycle survives
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stat_q <= BRF_EV_RST;
    end else if (reg_rd && reg_addr == BRF_STAT_OFS) begin
      stat_q <= ev_set;
    end else begin
      stat_q <= stat_q | ev_set;
    end
  end

  // Read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      if (reg_addr == BRF_CTRL_OFS) begin
        rdata_q <= {{(BRF_DW-BRF_CTRL_W){1'b0}}, ctrl_q};
      end else if (reg_addr == BRF_STAT_OFS) begin
        rdata_q <= {{(BRF_DW-BRF_EV_W){1'b0}}, stat_q};
      end else if (reg_addr == BRF_MASK_OFS) begin
        rdata_q <= {{(BRF_DW-BRF_EV_W){1'b0}}, mask_q};
      end else if (reg_addr == BRF_CFG_OFS) begin
        rdata_q <= {{(BRF_DW-BRF_CFG_W){1'b0}}, cfg_q};
      end else begin
        rdata_q <= '0;
      end
    end else begin
      rdata_q <= '0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |((stat_q | ev_set) & mask_q);
    end
  end

  // Sideband error pins, one-cycle low pulse per event in the standard modes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fatal_n_q    <= 1'b1;
      nonfatal_n_q <= 1'b1;
      pperr_n_q    <= 1'b1;
    end else begin
      fatal_n_q    <= !(std_mode && ((serr_fwd && cfg_q[BRF_CFG_SERR_FATAL]) ||
                                     (aperr && cfg_q[BRF_CFG_PERR_FATAL])));
      nonfatal_n_q <= !(std_mode && ((serr_fwd && !cfg_q[BRF_CFG_SERR_FATAL]) ||
                                     (aperr && !cfg_q[BRF_CFG_PERR_FATAL])));
      pperr_n_q    <= !(std_mode && dperr);
    end
  end

  // Flooding; sync packets paced by the sampled link clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flood_q  <= 1'b0;
      l0_stb_q <= 1'b0;
      l1_stb_q <= 1'b0;
    end else begin
      flood_q  <= flood_q || flood_req;
      l0_stb_q <= flood_q && lclk_rise;
      l1_stb_q <= flood_q && lclk_rise;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pkt_derr_q <= 1'b0;
    end else begin
      pkt_derr_q <= dperr;
    end
  end

  assign reg_rdata                  = rdata_q;
  assign io_fwd_valid               = fwd_valid_q;
  assign io_fwd_ok                  = fwd_ok_q;
  assign sync_flood                 = flood_q;
  assign link0_sync_stb             = l0_stb_q;
  assign link1_sync_stb             = l1_stb_q;
  assign pkt_data_error             = pkt_derr_q;
  assign fatal_error_out_n          = fatal_n_q;
  assign nonfatal_error_out_n       = nonfatal_n_q;
  assign primary_parity_error_out_n = pperr_n_q;
  assign irq                        = irq_q;

endmodule : brf_bridge_ctl

// [tb/brf_bridge_ctl_sva.sv]
module brf_bridge_ctl_sva
  import brf_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 sys_rst,
  input wire logic [BRF_AW-1:0]    reg_addr,
  input wire logic [BRF_DW-1:0]    reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 alt_mode_sel,
  input wire logic                 cmd_serr_enable,
  input wire logic [BRF_IO_AW-1:0] io_base,
  input wire logic [BRF_IO_AW-1:0] io_limit,
  input wire brf_io_req_s          io_req,
  input wire logic                 io_fwd_valid,
  input wire logic                 io_fwd_ok,
  input wire brf_perr_s            sec_perr,
  input wire logic                 sync_flood,
  input wire logic                 pkt_data_error,
  input wire logic                 primary_parity_error_out_n
);
  logic [2:0] ctl_q;
  logic       alt_q;
  logic       win;
  logic       hit;
  // Shadow of the control bits, kept from the register writes
  always_ff @(posedge clk) begin
    if (sys_rst) ctl_q <= 3'h0;
    else if (reg_wr && reg_addr == BRF_CTRL_OFS) ctl_q <= reg_wdata[2:0];
  end
  // Strap is static in the bench, so the raw pin stands for the synced one
  always_ff @(posedge clk) begin
    if (sys_rst) alt_q <= alt_mode_sel;
  end
  assign win = io_req.addr >= io_base && io_req.addr <= io_limit;
  assign hit = ctl_q[2] && win && io_req.addr[31:16] == 16'h0000 && io_req.addr[9:8] != 2'h0;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  fwd_pulse_a: assert property (io_req.valid |=> io_fwd_valid) else $error("decode answer missing");
  fwd_idle_a: assert property (!io_req.valid |=> !io_fwd_valid && !io_fwd_ok) else $error("stray decode");
  isa_block_a: assert property (io_req.valid && !io_req.upstream && hit |=> !io_fwd_ok) else $error("alias passed");
  isa_pass_a: assert property (io_req.valid && io_req.upstream && hit |=> io_fwd_ok) else $error("alias held");
  plain_fwd_a: assert property (io_req.valid && !io_req.upstream && !ctl_q[2] && win |=> io_fwd_ok)
    else $error("window not forwarded");
  perr_mark_a: assert property (ctl_q[0] && (sec_perr.mst_data_perr || sec_perr.tgt_data_perr) |=> pkt_data_error)
    else $error("packet not marked");
  perr_gate_a: assert property (!ctl_q[0] |=> !pkt_data_error && primary_parity_error_out_n)
    else $error("parity effect while disabled");
  std_pin_a: assert property (!alt_q && ctl_q[0] && sec_perr.mst_data_perr |=> !primary_parity_error_out_n)
    else $error("parity pin missing");
  flood_start_a: assert property (alt_q && ctl_q[0] && cmd_serr_enable && sec_perr.addr_perr |=> sync_flood)
    else $error("flood missing");
  flood_hold_a: assert property (sync_flood |=> sync_flood) else $error("flood ended");
  std_noflood_a: assert property (!alt_q |-> !sync_flood) else $error("flood in standard mode");
  cover property ($rose(sync_flood));
  cover property ($fell(primary_parity_error_out_n));
  cover property (io_req.valid && hit);
endmodule : brf_bridge_ctl_sva

bind brf_bridge_ctl brf_bridge_ctl_sva u_sva (.*);

// [tb/brf_sec_agent.sv]
module brf_sec_agent
  import brf_pkg::*;
(
  input wire logic clk,
  output brf_perr_s sec_perr,
  output logic      sec_serr_n,
  output logic      link_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  // Link clock runs free, unrelated in phase to clk
  initial begin
    sec_perr = '0;
    sec_serr_n = 1'b1;
    link_clk = 1'b0;
    #3;
    forever #80 link_clk = ~link_clk;
  end
  task perr(input brf_perr_s v);
    @(posedge clk);
    sec_perr <= v;
    @(posedge clk);
    sec_perr <= '0;
  endtask : perr
  // Open drain with pull-up: a release shows as high
  task line(input logic v);
    @(posedge clk);
    sec_serr_n <= v;
  endtask : line
endmodule : brf_sec_agent

// [tb/brf_bridge_ctl_tb_top.sv]
module brf_bridge_ctl_tb_top;
  import brf_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic                 clk, sys_rst, reg_wr, reg_rd, alt_mode_sel, cmd_serr_enable;
  logic [BRF_AW-1:0]    reg_addr;
  logic [BRF_DW-1:0]    reg_wdata, reg_rdata;
  logic [BRF_IO_AW-1:0] io_base, io_limit, a, b;
  brf_io_req_s          io_req;
  brf_perr_s            sec_perr;
  logic                 sec_serr_n, link_clk, sync_flood, link0_sync_stb, link1_sync_stb, pkt_data_error;
  logic                 fatal_error_out_n, nonfatal_error_out_n, primary_parity_error_out_n;
  logic                 io_fwd_valid, io_fwd_ok, irq;
  int                   n_fail, checks_done, cyc, seed, i;
  brf_sec_agent agent (.clk(clk), .sec_perr(sec_perr), .sec_serr_n(sec_serr_n), .link_clk(link_clk));
  brf_bridge_ctl dut (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task finish_test();
    if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      finish_test();
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task rst(input logic m);
    @(posedge clk);
    alt_mode_sel <= m;
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
  endtask : rst
  task wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input string nm, input logic [7:0] ad, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(nm, e, reg_rdata);
  endtask : rd
  function automatic logic exp_ok(logic up, logic [31:0] ad, logic isa, logic [31:0] lo, logic [31:0] hi);
    logic w, h;
    w = ad >= lo && ad <= hi;
    h = isa && w && ad[31:16] == 16'h0000 && ad[9:8] != 2'h0;
    return up ? (!w || h) : (w && !h);
  endfunction : exp_ok
  task io(input logic up, input logic isa);
    @(posedge clk);
    io_req <= '{1'b1, up, a};
    io_base <= b;
    io_limit <= b + ($random(seed) & 32'h0001_FFFF);
    @(posedge clk);
    io_req <= '0;
    #1 chk("fwd_valid", 32'h1, io_fwd_valid);
    chk("fwd_ok", {31'h0, exp_ok(up, a, isa, io_base, io_limit)}, io_fwd_ok);
  endtask : io
  task waitv(input int which, input logic v);
    i = 0;
    while (i < 40 && (which == 0 ? fatal_error_out_n : which == 1 ? sync_flood : link0_sync_stb) !== v) begin
      @(posedge clk);
      #1 i++;
    end
  endtask : waitv
  initial begin
    seed = 77321;
    {sys_rst, reg_wr, reg_rd, alt_mode_sel, cmd_serr_enable} = 5'h10;
    {reg_addr, reg_wdata, io_base, io_limit, io_req} = '0;
    rst(1'b0);
    rd("ctrl", BRF_CTRL_OFS, 32'h0);
    wr(BRF_CTRL_OFS, $random(seed) | 32'h7);
    rd("ctrl", BRF_CTRL_OFS, 32'h7);
    rd("unmapped", 8'h10 | (8'($random(seed)) & 8'hF0), 32'h0);
    for (int k = 0; k < 400; k++) begin
      if (k == 200) wr(BRF_CTRL_OFS, 32'h0);
      b = $random(seed) & 32'h0000_FFFF;
      a = b + ($random(seed) & 32'h0001_FFFF) - 32'h200;
      io($random(seed) & 1, k < 200);
    end
    wr(BRF_MASK_OFS, 32'h3F);
    // Random error traffic with every response bit clear must leave no trace
    for (int k = 0; k < 24; k++) begin
      @(posedge clk) cmd_serr_enable <= 1'($random(seed));
      agent.line(1'($random(seed)));
      agent.perr(4'($random(seed)));
      #1 chk("pkt_off", 32'h0, pkt_data_error);
    end
    agent.line(1'b1);
    rd("stat_off", BRF_STAT_OFS, 32'h0);
    wr(BRF_CTRL_OFS, 32'h1);
    agent.perr(4'h4);
    #1 chk("pkt", 32'h1, pkt_data_error);
    chk("perr_pin", 32'h0, primary_parity_error_out_n);
    chk("irq", 32'h1, irq);
    rd("stat_mst", BRF_STAT_OFS, 32'h4);
    @(posedge clk);
    #1 chk("irq_clr", 32'h0, irq);
    agent.perr(4'h2);
    rd("stat_tgt", BRF_STAT_OFS, 32'h2);
    agent.perr(4'h9);
    #1 chk("nonfatal", 32'h0, nonfatal_error_out_n);
    rd("stat_addr", BRF_STAT_OFS, 32'h1A);
    wr(BRF_MASK_OFS, 32'h0);
    agent.perr(4'h4);
    #1 chk("irq_mask", 32'h0, irq);
    wr(BRF_CTRL_OFS, 32'h3);
    wr(BRF_CFG_OFS, 32'h1);
    @(posedge clk) cmd_serr_enable <= 1'b1;
    agent.line(1'b0);
    waitv(0, 1'b0);
    chk("fatal", 32'h0, fatal_error_out_n);
    agent.line(1'b1);
    rd("stat_serr", BRF_STAT_OFS, 32'h15);
    rst(1'b1);
    rd("ctrl_warm", BRF_CTRL_OFS, 32'h0);
    wr(BRF_CTRL_OFS, 32'h1);
    @(posedge clk) cmd_serr_enable <= 1'b0;
    agent.perr(4'h8);
    #1 chk("no_flood", 32'h0, sync_flood);
    chk("pin_alt", 32'h1, nonfatal_error_out_n);
    rd("stat_alt", BRF_STAT_OFS, 32'h12);
    @(posedge clk) cmd_serr_enable <= 1'b1;
    agent.perr(4'h8);
    #1 chk("flood", 32'h1, sync_flood);
    waitv(2, 1'b1);
    chk("sync0", 32'h1, link0_sync_stb);
    chk("sync1", 32'h1, link1_sync_stb);
    rst(1'b1);
    wr(BRF_CTRL_OFS, 32'h2);
    agent.line(1'b0);
    waitv(1, 1'b1);
    chk("serr_flood", 32'h1, sync_flood);
    agent.line(1'b1);
    finish_test();
  end
endmodule : brf_bridge_ctl_tb_top
